// ===== rtl/rpm_port_bank.sv
`timescale 1ns/1ns
`include "rpm_regs.svh"
// How it works
// RULE_01: Register accesses reach the copy of the port whose index the port-select register holds, set by the host first.
// RULE_02: The first message byte is a plain read/write byte that resets to zero.
// RULE_03: The second message byte is the same plain read/write byte but resets to one.
// RULE_04: Status bit 3 sets when a long packet's byte count differs from its header word count.
// RULE_05: Status bit 2 sets when the payload CRC computed differs from the one carried by the packet.
// RULE_06: Status bit 1 sets on a multi-bit header ECC error and that header is passed on uncorrected.
// RULE_07: Status bit 0 sets on a single-bit header ECC error and the header is corrected before use.
// RULE_08: Every error flag stays set once raised until software clears it.
// RULE_09: Reading the status register returns the flags and then clears all four.
// RULE_10: An error seen in the clearing cycle keeps its flag set, and bits 7:4 read as zero.
module rpm_port_bank #(
	parameter int NUM_PORTS = 2
) (
	input wire logic clock,
	input wire logic rst,
	input rpm_pkg::rpm_reg_req_t regReq,
	output logic [7:0] regRdata,
	output logic regRdValid,
	input rpm_pkg::rpm_pkt_t [NUM_PORTS-1:0] pktIn,
	output logic [NUM_PORTS-1:0][23:0] hdrOut,
	output logic [NUM_PORTS-1:0] hdrOutValid,
	output rpm_pkg::rpm_err_t [NUM_PORTS-1:0] errEvent
);

	function automatic logic [15:0] crcByte(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc;
		for (int i = 0; i < 8; i++) begin
			if (c[0] ^ b[i]) begin
				c = (c >> 1) ^ `RPM_CRC_POLY;
			end else begin
				c = c >> 1;
			end
		end
		return c;
	endfunction

	// Selector decode shared by the write and read paths
	function automatic logic portHit(input logic ok, input logic [`RPM_PORT_SEL_W-1:0] idx, input int p);
		return ok && (int'(idx) == p);
	endfunction

	// Short packets carry no payload, so their bytes are never counted
	function automatic logic isLongType(input logic [5:0] dt);
		return dt >= `RPM_LONG_DT_MIN;
	endfunction

	// Reserved upper bits always read as zero
	function automatic logic [7:0] flagsByte(input logic [`RPM_FLAGS_W-1:0] f);
		return {4'h0, f};
	endfunction

	// Packet checking, one copy per port
	rpm_pkg::rpm_err_t [NUM_PORTS-1:0] portEvent;

	for (genvar p = 0; p < NUM_PORTS; p++) begin : gPort
		logic [23:0] hdrFixed;
		logic singleFixed;
		logic multiFault;
		logic [15:0] count_reg;
		logic [15:0] count_next;
		logic [15:0] crc_reg;
		logic [15:0] crc_next;
		logic [15:0] wordCount_reg;
		logic [15:0] wordCount_next;
		logic inLong_reg;
		logic inLong_next;
		logic [23:0] hdrOut_reg;
		logic [23:0] hdrOut_next;
		logic hdrValid_reg;
		logic hdrValid_next;
		rpm_pkg::rpm_err_t event_reg;
		rpm_pkg::rpm_err_t event_next;

		rpm_hdr_ecc uEcc (
			.hdrIn(pktIn[p].hdr),
			.eccIn(pktIn[p].ecc),
			.hdrFixed(hdrFixed),
			.singleFixed(singleFixed),
			.multiFault(multiFault)
		);

		always_comb begin
			count_next = count_reg;
			crc_next = crc_reg;
			wordCount_next = wordCount_reg;
			inLong_next = inLong_reg;
			hdrOut_next = hdrOut_reg;
			hdrValid_next = 1'b0;
			event_next = '0;
			// A new header always restarts the payload checks
			if (pktIn[p].hdrValid) begin
				hdrOut_next = hdrFixed; // RULE_07
				hdrValid_next = 1'b1;
				event_next.header_singlebit_fixed_flag = singleFixed; // RULE_07
				event_next.header_multibit_fault_flag = multiFault; // RULE_06
				wordCount_next = hdrFixed[23:8];
				inLong_next = isLongType(hdrFixed[5:0]);
				count_next = 16'h0000;
				crc_next = `RPM_CRC_INIT;
			end else if (inLong_reg) begin
				if (pktIn[p].byteValid) begin
					count_next = count_reg + 16'h0001;
					crc_next = crcByte(crc_reg, pktIn[p].byteData);
				end
				if (pktIn[p].endValid) begin
					event_next.lengthErr = count_next != wordCount_reg; // RULE_04
					event_next.payload_check_fail_flag = crc_next != pktIn[p].crcRx; // RULE_05
					inLong_next = 1'b0;
				end
			end
		end

		always_ff @(posedge clock) begin
			if (rst) begin
				count_reg <= 16'h0000;
				crc_reg <= `RPM_CRC_INIT;
				wordCount_reg <= 16'h0000;
				inLong_reg <= 1'b0;
				hdrOut_reg <= 24'h00_0000;
				hdrValid_reg <= 1'b0;
				event_reg <= '0;
			end else begin
				count_reg <= count_next;
				crc_reg <= crc_next;
				wordCount_reg <= wordCount_next;
				inLong_reg <= inLong_next;
				hdrOut_reg <= hdrOut_next;
				hdrValid_reg <= hdrValid_next;
				event_reg <= event_next;
			end
		end

		assign portEvent[p] = event_reg;
		assign hdrOut[p] = hdrOut_reg;
		assign hdrOutValid[p] = hdrValid_reg;
	end

	assign errEvent = portEvent;

	// Register bank
	logic [7:0] portSel_reg;
	logic [7:0] portSel_next;
	logic [NUM_PORTS-1:0][7:0] msgA_reg;
	logic [NUM_PORTS-1:0][7:0] msgA_next;
	logic [NUM_PORTS-1:0][7:0] msgB_reg;
	logic [NUM_PORTS-1:0][7:0] msgB_next;
	logic [NUM_PORTS-1:0][`RPM_FLAGS_W-1:0] flags_reg;
	logic [NUM_PORTS-1:0][`RPM_FLAGS_W-1:0] flags_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic rdValid_reg;
	logic rdValid_next;
	logic [`RPM_PORT_SEL_W-1:0] selIdx;
	logic selOk;

	always_comb begin
		selIdx = portSel_reg[`RPM_PORT_SEL_LSB +: `RPM_PORT_SEL_W];
		// An index beyond the last port reaches nothing and reads zero
		selOk = int'(selIdx) < NUM_PORTS; // RULE_01
		portSel_next = portSel_reg;
		msgA_next = msgA_reg;
		msgB_next = msgB_reg;
		rdata_next = rdata_reg;
		// Every read answers one cycle later, mapped or not
		rdValid_next = regReq.read;
		for (int p = 0; p < NUM_PORTS; p++) begin
			flags_next[p] = flags_reg[p] | portEvent[p]; // RULE_08
		end
		if (regReq.write) begin
			// Port select itself is shared by all ports
			if (regReq.addr == `RPM_ADDR_PORT_SEL) begin
				portSel_next = regReq.wdata;
			end
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (portHit(selOk, selIdx, p)) begin // RULE_01
					if (regReq.addr == `RPM_ADDR_MSG_A) begin
						msgA_next[p] = regReq.wdata; // RULE_02
					end
					if (regReq.addr == `RPM_ADDR_MSG_B) begin
						msgB_next[p] = regReq.wdata; // RULE_03
					end
				end
			end
		end
		if (regReq.read) begin
			rdata_next = 8'h00;
			if (regReq.addr == `RPM_ADDR_PORT_SEL) begin
				rdata_next = portSel_reg;
			end
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (portHit(selOk, selIdx, p)) begin // RULE_01
					case (regReq.addr)
						`RPM_ADDR_MSG_A: begin
							rdata_next = msgA_reg[p]; // RULE_02
						end
						`RPM_ADDR_MSG_B: begin
							rdata_next = msgB_reg[p]; // RULE_03
						end
						`RPM_ADDR_ERR_FLAGS: begin
							rdata_next = flagsByte(flags_reg[p]); // RULE_10
							// Clear, but a same-cycle event survives
							flags_next[p] = portEvent[p]; // RULE_09 RULE_10
						end
						default: begin
							rdata_next = 8'h00;
						end
					endcase
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			portSel_reg <= `RPM_RST_PORT_SEL;
			for (int p = 0; p < NUM_PORTS; p++) begin
				msgA_reg[p] <= `RPM_RST_MSG_A; // RULE_02
				msgB_reg[p] <= `RPM_RST_MSG_B; // RULE_03
				flags_reg[p] <= `RPM_RST_ERR_FLAGS;
			end
			rdata_reg <= 8'h00;
			rdValid_reg <= 1'b0;
		end else begin
			portSel_reg <= portSel_next;
			msgA_reg <= msgA_next;
			msgB_reg <= msgB_next;
			flags_reg <= flags_next;
			rdata_reg <= rdata_next;
			rdValid_reg <= rdValid_next;
		end
	end

	assign regRdata = rdata_reg;
	assign regRdValid = rdValid_reg;

endmodule

// ===== common/rpm_regs.svh
`ifndef RPM_REGS_SVH
`define RPM_REGS_SVH

// Register offsets on the port-register access path
`define RPM_ADDR_PORT_SEL 8'h4C
`define RPM_ADDR_MSG_A 8'h78
`define RPM_ADDR_MSG_B 8'h79
`define RPM_ADDR_ERR_FLAGS 8'h7A

// Reset values
`define RPM_RST_PORT_SEL 8'h00
`define RPM_RST_MSG_A 8'h00
`define RPM_RST_MSG_B 8'h01
`define RPM_RST_ERR_FLAGS 4'h0

// Port-select field: index of the port that register accesses reach
`define RPM_PORT_SEL_LSB 0
`define RPM_PORT_SEL_W 2

// Status field positions
`define RPM_BIT_LENGTH 3
`define RPM_BIT_CKSUM 2
`define RPM_BIT_MULTI 1
`define RPM_BIT_SINGLE 0
`define RPM_FLAGS_W 4

// Payload checksum: CRC-16, x16+x12+x5+1, bit-reversed, LSB first
`define RPM_CRC_INIT 16'hFFFF
`define RPM_CRC_POLY 16'h8408

// Data types below this carry no payload
`define RPM_LONG_DT_MIN 6'h10

`endif

// ===== common/rpm_pkg.sv
package rpm_pkg;

	// Field order matches status bits 3..0
	typedef struct packed {
		logic lengthErr;
		logic payload_check_fail_flag;
		logic header_multibit_fault_flag;
		logic header_singlebit_fixed_flag;
	} rpm_err_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rpm_reg_req_t;

	typedef struct packed {
		logic hdrValid;
		logic [23:0] hdr;
		logic [7:0] ecc;
		logic byteValid;
		logic [7:0] byteData;
		logic endValid;
		logic [15:0] crcRx;
	} rpm_pkt_t;

endpackage

// ===== rtl/rpm_hdr_ecc.sv
`timescale 1ns/1ns
module rpm_hdr_ecc (
	input wire logic [23:0] hdrIn,
	input wire logic [7:0] eccIn,
	output logic [23:0] hdrFixed,
	output logic singleFixed,
	output logic multiFault
);

	function automatic logic [5:0] eccColumn(input int i);
		case (i)
			0: eccColumn = 6'h07;
			1: eccColumn = 6'h0B;
			2: eccColumn = 6'h0D;
			3: eccColumn = 6'h0E;
			4: eccColumn = 6'h13;
			5: eccColumn = 6'h15;
			6: eccColumn = 6'h16;
			7: eccColumn = 6'h19;
			8: eccColumn = 6'h1A;
			9: eccColumn = 6'h1C;
			10: eccColumn = 6'h23;
			11: eccColumn = 6'h25;
			12: eccColumn = 6'h26;
			13: eccColumn = 6'h29;
			14: eccColumn = 6'h2A;
			15: eccColumn = 6'h2C;
			16: eccColumn = 6'h31;
			17: eccColumn = 6'h32;
			18: eccColumn = 6'h34;
			19: eccColumn = 6'h38;
			20: eccColumn = 6'h1F;
			21: eccColumn = 6'h2F;
			22: eccColumn = 6'h37;
			23: eccColumn = 6'h3B;
			default: eccColumn = 6'h00;
		endcase
	endfunction

	function automatic logic [5:0] computeEcc(input logic [23:0] d);
		logic [5:0] p;
		p = 6'h00;
		for (int i = 0; i < 24; i++) begin
			if (d[i]) begin
				p = p ^ eccColumn(i);
			end
		end
		return p;
	endfunction

	logic [5:0] syndrome;
	logic hit;
	logic parityOnly;

	always_comb begin
		syndrome = computeEcc(hdrIn) ^ eccIn[5:0];
		hdrFixed = hdrIn;
		hit = 1'b0;
		for (int i = 0; i < 24; i++) begin
			if (syndrome == eccColumn(i)) begin
				hdrFixed[i] = ~hdrIn[i];
				hit = 1'b1;
			end
		end
		// A lone flipped check bit leaves the header itself intact
		parityOnly = (syndrome != 6'h00) && ((syndrome & (syndrome - 6'h01)) == 6'h00);
		singleFixed = hit | parityOnly; // RULE_07
		multiFault = (syndrome != 6'h00) && !hit && !parityOnly; // RULE_06
		if (multiFault) begin
			hdrFixed = hdrIn; // RULE_06
		end
	end

endmodule

// ===== tb/rpm_properties.sv
`timescale 1ns/1ns
`include "rpm_regs.svh"
module rpm_properties #(
	parameter int NUM_PORTS = 2
) (
	input logic clock,
	input logic rst,
	input rpm_pkg::rpm_reg_req_t regReq,
	input logic [7:0] regRdata,
	input logic regRdValid,
	input rpm_pkg::rpm_pkt_t [NUM_PORTS-1:0] pktIn,
	input logic [NUM_PORTS-1:0][23:0] hdrOut,
	input logic [NUM_PORTS-1:0] hdrOutValid,
	input rpm_pkg::rpm_err_t [NUM_PORTS-1:0] errEvent
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Quiet event path, so nothing may re-arm a flag between two reads
	sequence rd_sts;
		regReq.read && !regReq.write && regReq.addr == `RPM_ADDR_ERR_FLAGS && errEvent == '0 && $past(errEvent) == '0;
	endsequence
	sequence wr_msg;
		regReq.write && !regReq.read && (regReq.addr == `RPM_ADDR_MSG_A || regReq.addr == `RPM_ADDR_MSG_B);
	endsequence
	a_read_answer: assert property (regRdValid == $past(regReq.read)) else $error("read answer late");
	a_clear_read: assert property (rd_sts ##1 rd_sts |=> regRdata == 8'h00) else $error("flags kept");
	a_msg_readback: assert property (wr_msg ##1 (regReq.read && !regReq.write && regReq.addr == $past(regReq.addr))
		|=> regRdata == $past(regReq.wdata, 2)) else $error("message lost");
	a_reserved_zero: assert property (regReq.read && regReq.addr == `RPM_ADDR_ERR_FLAGS |=> regRdata[7:4] == 4'h0)
		else $error("reserved set");
	a_unmapped_zero: assert property (regReq.read && !(regReq.addr inside {8'h4C, 8'h78, 8'h79, 8'h7A})
		|=> regRdata == 8'h00) else $error("unmapped data");
	a_hdr_answer: assert property (hdrOutValid[0] == $past(pktIn[0].hdrValid)) else $error("header late");
	a_ecc_cause: assert property (errEvent[0].header_singlebit_fixed_flag || errEvent[0].header_multibit_fault_flag
		|-> $past(pktIn[0].hdrValid) && !(errEvent[0].header_singlebit_fixed_flag
		&& errEvent[0].header_multibit_fault_flag)) else $error("ecc event");
	a_end_cause: assert property (errEvent[0].lengthErr || errEvent[0].payload_check_fail_flag
		|-> $past(pktIn[0].endValid)) else $error("payload event");
endmodule
bind rpm_port_bank rpm_properties #(.NUM_PORTS(NUM_PORTS)) u_props (.clock(clock), .rst(rst), .regReq(regReq),
	.regRdata(regRdata), .regRdValid(regRdValid), .pktIn(pktIn), .hdrOut(hdrOut), .hdrOutValid(hdrOutValid),
	.errEvent(errEvent));

// ===== tb/rpm_sensor_model.sv
`timescale 1ns/1ns
`include "rpm_regs.svh"
module rpm_sensor_model (
	input wire logic clock,
	output rpm_pkg::rpm_pkt_t pkt
);
	localparam logic [23:0] ECC_MASK [6] = '{24'hF1_2CB7, 24'hF2_555B, 24'h74_9A6D, 24'hB8_E38E, 24'hDF_03F0,
		24'hEF_FC00};
	initial pkt = '0;
	// Unqualified fields invert every beat so stale data never passes
	task automatic send(input logic [15:0] wc, input int n, input logic [23:0] flip, input logic [15:0] crcFlip);
		rpm_pkg::rpm_pkt_t p;
		logic [15:0] crc;
		crc = `RPM_CRC_INIT;
		p = ~pkt;
		p.byteValid = 1'b0;
		p.endValid = 1'b0;
		p.hdrValid = 1'b1;
		p.hdr = {wc, 8'h2A};
		for (int i = 0; i < 6; i++) p.ecc[i] = ^(p.hdr & ECC_MASK[i]);
		p.hdr = p.hdr ^ flip;
		@(posedge clock);
		pkt <= p;
		for (int i = 0; i < n; i++) begin
			p = ~p;
			p.hdrValid = 1'b0;
			p.byteValid = 1'b1;
			p.byteData = 8'($urandom);
			p.endValid = (i == n - 1);
			crc = crc ^ {8'h00, p.byteData};
			for (int j = 0; j < 8; j++) crc = crc[0] ? (crc >> 1) ^ `RPM_CRC_POLY : crc >> 1;
			p.crcRx = crc ^ crcFlip;
			@(posedge clock);
			pkt <= p;
		end
		p = ~p;
		{p.hdrValid, p.byteValid, p.endValid} = 3'b000;
		@(posedge clock);
		pkt <= p;
	endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ns
`include "rpm_regs.svh"
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin err_count++; $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
	logic clock = 1'b0;
	logic rst = 1'b1;
	rpm_pkg::rpm_reg_req_t regReq = '0;
	logic [7:0] regRdata;
	logic regRdValid;
	rpm_pkg::rpm_pkt_t [1:0] pktIn;
	logic [1:0][23:0] hdrOut;
	logic [1:0] hdrOutValid;
	rpm_pkg::rpm_err_t [1:0] errEvent;
	logic [7:0] rdQ [$];
	logic [23:0] hdrQ [$];
	logic [23:0] hdr1Q [$];
	logic [7:0] expRd;
	logic [23:0] expHdr;
	logic [7:0] ma [2];
	logic [7:0] mb [2];
	logic [15:0] cWc [5] = '{16'h0002, 16'h0003, 16'h0002, 16'h0002, 16'h0002};
	logic [15:0] cCrc [5] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
	logic [23:0] cFlip [5] = '{24'h00_0000, 24'h00_0000, 24'h00_0000, 24'h00_0003, 24'h00_0020};
	logic [7:0] cExp [5] = '{8'h00, 8'h08, 8'h04, 8'h02, 8'h01};
	int err_count = 0;
	int n_tests = 0;
	always #20 clock = ~clock;
	rpm_port_bank #(.NUM_PORTS(2)) dut (.clock(clock), .rst(rst), .regReq(regReq), .regRdata(regRdata),
		.regRdValid(regRdValid), .pktIn(pktIn), .hdrOut(hdrOut), .hdrOutValid(hdrOutValid), .errEvent(errEvent));
	rpm_sensor_model src0 (.clock(clock), .pkt(pktIn[0]));
	rpm_sensor_model src1 (.clock(clock), .pkt(pktIn[1]));
	// Strobes stay up for back-to-back use; idle drops them
	task automatic req(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		@(posedge clock);
		regReq <= '{read: r, write: w, addr: a, wdata: d};
		if (r) rdQ.push_back(e);
	endtask
	task automatic idle(input int n);
		@(posedge clock);
		regReq <= '0;
		repeat (n) @(posedge clock);
	endtask
	task automatic give_verdict();
		if (err_count == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(negedge clock) begin
		if (regRdValid === 1'b1) begin
			expRd = rdQ.pop_front();
			`CHK("read data", expRd, regRdata)
		end
		if (hdrOutValid[0] === 1'b1) begin
			expHdr = hdrQ.pop_front();
			`CHK("header", expHdr, hdrOut[0])
		end
		if (hdrOutValid[1] === 1'b1) begin
			expHdr = hdr1Q.pop_front();
			`CHK("header port 1", expHdr, hdrOut[1])
		end
	end
	initial begin
		#400000;
		err_count++;
		give_verdict();
	end
	initial begin
		void'($urandom(41));
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		req(1, 0, `RPM_ADDR_PORT_SEL, 8'h00, 8'h00);
		req(1, 0, `RPM_ADDR_MSG_A, 8'h00, 8'h00);
		req(1, 0, `RPM_ADDR_MSG_B, 8'h00, 8'h01);
		req(1, 0, `RPM_ADDR_ERR_FLAGS, 8'h00, 8'h00);
		req(1, 0, 8'h7B, 8'h00, 8'h00);
		for (int p = 0; p < 2; p++) begin
			ma[p] = 8'($urandom);
			mb[p] = 8'($urandom);
			req(0, 1, `RPM_ADDR_PORT_SEL, 8'(p), 8'h00);
			req(0, 1, `RPM_ADDR_MSG_A, ma[p], 8'h00);
			req(1, 0, `RPM_ADDR_MSG_A, 8'h00, ma[p]);
			req(0, 1, `RPM_ADDR_MSG_B, mb[p], 8'h00);
			req(1, 0, `RPM_ADDR_MSG_B, 8'h00, mb[p]);
		end
		for (int p = 0; p < 2; p++) begin
			req(0, 1, `RPM_ADDR_PORT_SEL, 8'(p), 8'h00);
			req(1, 0, `RPM_ADDR_MSG_A, 8'h00, ma[p]);
			req(1, 0, `RPM_ADDR_MSG_B, 8'h00, mb[p]);
		end
		req(0, 1, `RPM_ADDR_PORT_SEL, 8'h00, 8'h00);
		idle(0);
		for (int k = 0; k < 5; k++) begin
			hdrQ.push_back({cWc[k], 8'h2A} ^ (k == 3 ? cFlip[k] : 24'h00_0000));
			src0.send(cWc[k], 2, cFlip[k], cCrc[k]);
			hdrQ.push_back({16'h0002, 8'h2A});
			src0.send(16'h0002, 2, 24'h00_0000, 16'h0000);
			idle(4);
			req(1, 0, `RPM_ADDR_ERR_FLAGS, 8'h00, cExp[k]);
			req(1, 0, `RPM_ADDR_ERR_FLAGS, 8'h00, 8'h00);
			idle(0);
		end
		hdr1Q.push_back({16'h0005, 8'h2A});
		src1.send(16'h0005, 2, 24'h00_0000, 16'h0000);
		idle(4);
		req(0, 1, `RPM_ADDR_PORT_SEL, 8'h01, 8'h00);
		req(1, 0, `RPM_ADDR_ERR_FLAGS, 8'h00, 8'h08);
		req(0, 1, `RPM_ADDR_PORT_SEL, 8'h00, 8'h00);
		req(1, 0, `RPM_ADDR_ERR_FLAGS, 8'h00, 8'h00);
		idle(3);
		`CHK("pending notes", 0, rdQ.size() + hdrQ.size() + hdr1Q.size())
		give_verdict();
	end
endmodule
